// File: dv/fbp_pins_model.sv
/* Far-side pins: a driven line shows the port's value, else the outside level.
   Assumes the bench changes that level for every set-up. */
module fbp_pins_model (
  input  wire logic [3:0] port_pin_out, port_pin_oe, ext_level,
  output logic      [3:0] port_pin_in
);
  assign port_pin_in = port_pin_oe & port_pin_out | ~port_pin_oe & ext_level;
endmodule

// File: dv/fbp_port_monitor.sv
/* Pin and read checks against register shadows kept from APB writes.
   Assumes it is bound to the port module. */
`include "fbp_consts.svh"
module fbp_port_monitor (
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr, strobe_n_in,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] cs_n_in, port_pin_in, port_pin_out, port_pin_oe, pin_fn_cs
);
  logic [3:0] d_r, o_r, cs, st, m;
  logic [10:0] c_r;
  logic alt;
  assign alt = c_r[10:8] inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6} || c_r[9:8] == 2'h3 && c_r[6];
  // Pin 3 mask drops when the strobe takes it
  assign m = {!(alt && c_r[5:4] == 2'h3), 3'h7};
  assign cs = alt ? c_r[3:0] & d_r & m : 4'h0;
  assign st = d_r & o_r | ~d_r & port_pin_in;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) begin
      d_r <= 4'h0;
      o_r <= 4'h0;
      c_r <= 11'h700;
    end else if (psel && penable && pwrite) begin
      if (paddr == `FBP_OFF_DIR) d_r <= pwdata[3:0];
      if (paddr == `FBP_OFF_OUT) o_r <= pwdata[3:0];
      if (paddr == `FBP_OFF_CTRL) c_r <= pwdata[10:0];
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  alt_gate_a: assert property (!alt |-> !pin_fn_cs) else $error("alt on");
  strobe_pin_a: assert property (!m[3] |-> port_pin_oe[3] && port_pin_out[3] == strobe_n_in)
    else $error("strobe");
  cs_select_a: assert property (pin_fn_cs == cs) else $error("cs select");
  cs_drive_a: assert property ((cs & (~port_pin_oe | port_pin_out ^ cs_n_in)) == 4'h0)
    else $error("cs drive");
  gpio_dir_a: assert property (((port_pin_oe ^ d_r) & m) == 4'h0) else $error("dir");
  gpio_data_a: assert property (((port_pin_out ^ o_r) & d_r & ~cs & m) == 4'h0) else $error("data");
  out_read_a: assert property (psel && !penable && !pwrite && paddr == `FBP_OFF_OUT |=> prdata == {28'h0, o_r})
    else $error("out read");
  state_read_a: assert property (psel && !penable && !pwrite && paddr == `FBP_OFF_STATE
    |=> prdata == {28'h0, $past(st)})
    else $error("state read");
  cover property (!m[3]);
  cover property (cs != 4'h0);
  cover property (pslverr);
endmodule
bind fbp_port fbp_port_monitor mon_u (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .strobe_n_in,
  .paddr, .pwdata, .prdata, .cs_n_in, .port_pin_in, .port_pin_out, .port_pin_oe, .pin_fn_cs);

// File: dv/fbp_port_tb.sv
/* Bench: random port set-ups over APB, reads checked against a model.
   Assumes the pin model and the monitor are compiled first. */
`include "fbp_consts.svh"
module fbp_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, strobe_n_in = 0, pready, pslverr, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] cs_n_in = 0, ext = 0, port_pin_in, port_pin_out, port_pin_oe, pin_fn_cs;
  int n_fail = 0, checked = 0, cyc = 0, seed = 32'h4FF1, dir, dat, ctl, stb;
  fbp_port dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cs_n_in, .strobe_n_in, .port_pin_in, .port_pin_out, .port_pin_oe, .pin_fn_cs);
  fbp_pins_model pins_u (.port_pin_out, .port_pin_oe, .ext_level(ext), .port_pin_in);
  always #12.5 pclk = ~pclk;
  always @(posedge pclk)
    if (++cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic report_and_stop();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, `FBP_OFF_OUT, 0);
    chk(rd, 0);
    chk(port_pin_oe, 0);
    for (int i = 0; i < 64; i++) begin
      dir = $random(seed) & 15;
      dat = $random(seed);
      ctl = $random(seed) & 32'h77F;
      cs_n_in <= 4'($random(seed));
      strobe_n_in <= 1'($random(seed));
      ext <= 4'($random(seed));
      apb(1, `FBP_OFF_DIR, dir | 32'hF0);
      apb(1, `FBP_OFF_OUT, dat);
      apb(1, `FBP_OFF_CTRL, ctl);
      apb(1, `FBP_OFF_STATE, ~dat);
      stb = ctl[5:4] == 3 && (ctl[10:8] inside {1, 2, 4, 5, 6} || ctl[9:8] == 3 && ctl[6]);
      apb(0, `FBP_OFF_OUT, 0);
      chk(rd, dat & 15);
      apb(0, `FBP_OFF_STATE, 0);
      chk(rd, (dir & dat | ~dir & (stb ? ext & 7 | strobe_n_in << 3 : ext)) & 15);
    end
    $display("random set-ups done");
    apb(0, `FBP_OFF_DIR, 0);
    chk(rd, 0);
    apb(0, 12'h010, 0);
    chk(err, 1);
    $display("write-only and unmapped reads done");
    report_and_stop();
  end
endmodule

// File: rtl/fbp_consts.svh
/*
  Offsets, field positions and reset values of the four-bit port.
  Assumes inclusion by bare name from the package and the port module.
*/
`ifndef FBP_CONSTS_SVH
`define FBP_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define FBP_OFF_DIR       12'h000
`define FBP_OFF_OUT       12'h004
`define FBP_OFF_STATE     12'h008
`define FBP_OFF_CTRL      12'h00C

// ==========================================================
// Control register fields
`define FBP_CTRL_CS_LSB   0
`define FBP_CTRL_STB_EN_BIT  4
`define FBP_CTRL_STB_SEL_BIT 5
`define FBP_CTRL_EXP_BIT  6
`define FBP_CTRL_MODE_LSB 8

// ==========================================================
// Reset values
`define FBP_DIR_RST       4'h0
`define FBP_OUT_RST       4'h0
`define FBP_CS_RST        4'h0
`define FBP_MODE_RST      3'h7

`endif

// File: rtl/fbp_pkg.sv
/*
  Types of the four-bit port.
  Assumes the constants header is on the include path.
*/
package fbp_pkg;
  `include "fbp_consts.svh"

  typedef enum logic [1:0] {
    FBP_FN_GPIO,
    FBP_FN_CS,
    FBP_FN_STROBE
  } fbp_fn_type;
endpackage

// File: rtl/fbp_port.sv
/*
  Four-bit general-purpose port with chip-select and output-enable
  strobe alternates, reached over APB.
  Assumes pins are synchronous to pclk; the bus controller provides
  chip-select and strobe levels, active low on the pins.
*/
// The register offsets and the APB interface to the registers are this design's own decisions.
// Overview of operation
// - Alternates in modes 1,2,4,5,6; modes 3,7 need expansion; mode 0 none
// - Strobe enable and select drive pin 3
// - Pin 3 chip-select when enabled, direction one, strobe off
// - Pin 3 plain I/O when chip-select and strobe off
// - Pins 2-0 chip-select when enabled, direction one
// - Pins 2-0 plain I/O when chip-select off
// - Modes 3,7 without expansion: plain I/O
// - Output data bits 3-0 read/write, reset zero
// - Output data bits 7-4 read zero
// - State read: data if output, else pin
// - State register read-only, writes ignored
// - State bits 7-4 reserved
// - Direction bits 7-4 reserved, reset zero
`include "fbp_consts.svh"

module fbp_port
  import fbp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  cs_n_in,
  input  wire logic        strobe_n_in,
  input  wire logic [3:0]  port_pin_in,
  output logic      [3:0]  port_pin_out,
  output logic      [3:0]  port_pin_oe,
  output logic      [3:0]  pin_fn_cs
);

  // ==========================================================
  // Registers
  logic [3:0] pin_direction_r;
  logic [3:0] pin_output_data_r;
  logic [3:0] cs_enable_r;
  logic       strobe_enable_r;
  logic       strobe_select_r;
  logic       expansion_enable_r;
  logic [2:0] mode_r;
  logic [31:0] prdata_r;

  logic wr_en;
  logic rd_en;
  logic addr_ok;

  fbp_fn_type pin_fn [4];
  logic [3:0] pin_state;
  logic       alt_ok;

  function automatic logic fbp_mapped(input logic [11:0] a);
    return a == `FBP_OFF_DIR || a == `FBP_OFF_OUT ||
           a == `FBP_OFF_STATE || a == `FBP_OFF_CTRL;
  endfunction

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign addr_ok = fbp_mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = prdata_r;

  // ==========================================================
  // Direction register, reserved upper bits not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction_r <= `FBP_DIR_RST;
    end else if (wr_en && paddr == `FBP_OFF_DIR) begin
      pin_direction_r <= pwdata[3:0];
    end
  end

  // ==========================================================
  // Output data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_output_data_r <= `FBP_OUT_RST;
    end else if (wr_en && paddr == `FBP_OFF_OUT) begin
      pin_output_data_r <= pwdata[3:0];
    end
  end

  // ==========================================================
  // Function control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_enable_r        <= `FBP_CS_RST;
      strobe_enable_r    <= 1'b0;
      strobe_select_r    <= 1'b0;
      expansion_enable_r <= 1'b0;
      mode_r             <= `FBP_MODE_RST;
    end else if (wr_en && paddr == `FBP_OFF_CTRL) begin
      cs_enable_r        <= pwdata[`FBP_CTRL_CS_LSB +: 4];
      strobe_enable_r    <= pwdata[`FBP_CTRL_STB_EN_BIT];
      strobe_select_r    <= pwdata[`FBP_CTRL_STB_SEL_BIT];
      expansion_enable_r <= pwdata[`FBP_CTRL_EXP_BIT];
      mode_r             <= pwdata[`FBP_CTRL_MODE_LSB +: 3];
    end
  end

  // ==========================================================
  // Pin function selection
  always_comb begin
    alt_ok = 1'b0;
    case (mode_r)
      3'h1, 3'h2, 3'h4, 3'h5, 3'h6: alt_ok = 1'b1;
      3'h3, 3'h7: alt_ok = expansion_enable_r;
      default: alt_ok = 1'b0;
    endcase
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_fn[i] = FBP_FN_GPIO;
      if (alt_ok && cs_enable_r[i] && pin_direction_r[i]) begin
        pin_fn[i] = FBP_FN_CS;
      end
    end
    if (alt_ok && strobe_enable_r && strobe_select_r) begin
      pin_fn[3] = FBP_FN_STROBE;
    end
  end

  // ==========================================================
  // Pin drivers
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      case (pin_fn[i])
        FBP_FN_STROBE: begin
          port_pin_out[i] = strobe_n_in;
          port_pin_oe[i]  = 1'b1;
          pin_fn_cs[i]    = 1'b0;
        end
        FBP_FN_CS: begin
          port_pin_out[i] = cs_n_in[i];
          port_pin_oe[i]  = 1'b1;
          pin_fn_cs[i]    = 1'b1;
        end
        default: begin
          port_pin_out[i] = pin_output_data_r[i];
          port_pin_oe[i]  = pin_direction_r[i];
          pin_fn_cs[i]    = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Pin-state view
  assign pin_state = (pin_direction_r & pin_output_data_r) |
                     (~pin_direction_r & port_pin_in);

  // ==========================================================
  // Read data; writes to the state view touch nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `FBP_OFF_DIR:   prdata_r <= 32'h0000_0000;
        `FBP_OFF_OUT:   prdata_r <= {28'h000_0000, pin_output_data_r};
        `FBP_OFF_STATE: prdata_r <= {28'h000_0000, pin_state};
        `FBP_OFF_CTRL:  prdata_r <= {21'h00_0000, mode_r, 1'b0, expansion_enable_r,
                                     strobe_select_r, strobe_enable_r, cs_enable_r};
        default:        prdata_r <= 32'h0000_0000;
      endcase
    end else if (!rd_en) begin
      prdata_r <= 32'h0000_0000;
    end
  end

endmodule
